// >>> hw/efp_pkg.sv
// Purpose: shared constants and types for the fetch and issue pipeline
// Assumes: 32-bit words, byte addresses, word-aligned instructions
// Notes:   instruction field positions are the core's own encoding
package efp_pkg;
	localparam int XLEN        = 32;
	localparam int NREG        = 32;
	localparam int REG_W       = 5;
	localparam int LINE_WORDS  = 4;
	localparam int LINE_BYTES  = 16;
	localparam int LINE_LSB    = 4;
	localparam int CACHE_BYTES = 512;
	localparam int CACHE_WORDS = CACHE_BYTES / 4;
	localparam int MAX_LOADS   = 3;
	localparam logic [31:0] RESET_PC = 32'h0000_0000;
	localparam logic [31:0] WORD_STEP = 32'h0000_0004;
	localparam logic [31:0] LINE_STEP = 32'h0000_0010;

	localparam int OPC_HI  = 31;
	localparam int OPC_LO  = 24;
	localparam int DST_HI  = 23;
	localparam int DST_LO  = 19;
	localparam int SRC1_HI = 18;
	localparam int SRC1_LO = 14;
	localparam int SRC2_HI = 4;
	localparam int SRC2_LO = 0;
	localparam int OFF_HI  = 11;
	localparam int DISP_HI = 23;
	localparam int DISP_LO = 2;
	localparam int COND_BIT  = 1;
	localparam int STORE_BIT = 0;

	typedef enum logic [2:0] {
		FMT_CTRL = 3'h0,
		FMT_COBR = 3'h1,
		FMT_REG  = 3'h2,
		FMT_MEMA = 3'h3,
		FMT_MEMB = 3'h4,
		FMT_NONE = 3'h7
	} efp_fmt_type;

	typedef enum logic [3:0] {
		ALU_MOV = 4'h0, ALU_ADD = 4'h1, ALU_SUB = 4'h2, ALU_AND = 4'h3,
		ALU_OR  = 4'h4, ALU_XOR = 4'h5, ALU_SHL = 4'h6, ALU_SHR = 4'h7,
		ALU_CMP = 4'h8
	} efp_alu_type;

	typedef enum logic [1:0] {
		F_IDLE  = 2'h0,
		F_REQ   = 2'h1,
		F_BURST = 2'h2
	} efp_fetch_type;

	// each major opcode maps to exactly one layout
	function automatic efp_fmt_type efp_fmt_of(input logic [7:0] opc);
		unique case (opc[7:4])
			4'h0, 4'h1: efp_fmt_of = FMT_CTRL;
			4'h2, 4'h3: efp_fmt_of = FMT_COBR;
			4'h5, 4'h6: efp_fmt_of = FMT_REG;
			4'h8:       efp_fmt_of = FMT_MEMA;
			4'h9:       efp_fmt_of = FMT_MEMB;
			default:    efp_fmt_of = FMT_NONE;
		endcase
	endfunction : efp_fmt_of
endpackage : efp_pkg

// >>> hw/efp_icache.sv
// Purpose: direct-mapped instruction store, one tag and valid per word
// Assumes: word-aligned byte addresses
// Notes:   per-word valid lets a half-filled line already hit
`timescale 1ns/1ps
module efp_icache
	import efp_pkg::*;
#(
	parameter int WORDS = CACHE_WORDS
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [31:0] rd_addr,
	output logic      [31:0] rd_data,
	output logic             rd_hit,
	input  wire logic [31:0] probe_addr,
	output logic             probe_hit,
	input  wire logic        wr_en,
	input  wire logic [31:0] wr_addr,
	input  wire logic [31:0] wr_data
);
	import efp_pkg::*;
	localparam int IW = $clog2(WORDS);
	localparam int TW = 32 - IW - 2;

	typedef struct packed {
		logic [WORDS-1:0][31:0]   data;
		logic [WORDS-1:0][TW-1:0] tag;
		logic [WORDS-1:0]         valid;
	} efp_ic_type;

	efp_ic_type s_r;
	efp_ic_type s_nxt;

	always_comb
	begin
		s_nxt = s_r;
		if (wr_en)
		begin
			s_nxt.data[wr_addr[IW+1:2]]  = wr_data;
			s_nxt.tag[wr_addr[IW+1:2]]   = wr_addr[31:IW+2];
			s_nxt.valid[wr_addr[IW+1:2]] = 1'b1;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign rd_data   = s_r.data[rd_addr[IW+1:2]];
	assign rd_hit    = s_r.valid[rd_addr[IW+1:2]] && (s_r.tag[rd_addr[IW+1:2]] == rd_addr[31:IW+2]);
	assign probe_hit = s_r.valid[probe_addr[IW+1:2]] && (s_r.tag[probe_addr[IW+1:2]] == probe_addr[31:IW+2]);
endmodule : efp_icache

// >>> hw/efp_core.sv
// Purpose: instruction fetch, decode and single-issue control with scoreboard
// Assumes: memory side answers burst fills in order, word 0 first
// Notes:   one instruction issues per cycle at most, strictly in program order
`timescale 1ns/1ps
module efp_core
	import efp_pkg::*;
#(
	parameter int LOADS = MAX_LOADS
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	output logic                  fill_req,
	output logic       [31:0]     fill_addr,
	input  wire logic             fill_gnt,
	input  wire logic             fill_beat_valid,
	input  wire logic  [31:0]     fill_beat_data,
	output logic                  mem_valid,
	output logic                  mem_write,
	output logic       [31:0]     mem_addr,
	output logic       [31:0]     mem_wdata,
	output logic       [REG_W-1:0] mem_tag,
	input  wire logic             mem_ready,
	input  wire logic             ld_rsp_valid,
	input  wire logic  [REG_W-1:0] ld_rsp_tag,
	input  wire logic  [31:0]     ld_rsp_data,
	output logic                  issue_pulse,
	output logic       [31:0]     issue_pc
);
	import efp_pkg::*;

	typedef struct packed {
		efp_fetch_type              fst;
		logic [31:0]                fill_addr;
		logic [1:0]                 fill_cnt;
		logic [31:0]                pc;
		logic [NREG-1:0][XLEN-1:0]  regs;
		logic [NREG-1:0]            sb;
		logic [1:0]                 ld_cnt;
		logic                       cc;
		logic                       cc_busy;
		logic                       ex_valid;
		efp_alu_type                ex_op;
		logic [REG_W-1:0]           ex_dst;
		logic [31:0]                ex_a;
		logic [31:0]                ex_b;
		logic                       mem_valid;
		logic                       mem_write;
		logic [31:0]                mem_addr;
		logic [31:0]                mem_wdata;
		logic [REG_W-1:0]           mem_tag;
		logic                       issued;
		logic [31:0]                issued_pc;
	} efp_state_type;

	localparam logic [1:0] LAST_BEAT = 2'(LINE_WORDS - 1);
	localparam logic [1:0] LOAD_CAP  = 2'(LOADS);

	efp_state_type s_r;
	efp_state_type s_nxt;

	logic [31:0]      ic_data;
	logic             ic_hit;
	logic             probe_hit;
	logic [31:0]      beat_addr;
	logic             fill_wr;
	logic             byp;
	logic             instr_ok;
	logic [31:0]      instr;
	efp_fmt_type      fmt;
	logic [REG_W-1:0] f_dst;
	logic [REG_W-1:0] f_s1;
	logic [REG_W-1:0] f_s2;
	logic             is_cond;
	logic             is_store;
	logic             is_mem;
	logic             rdy;
	logic             issue;
	logic             ex_fwd;
	logic [31:0]      ex_res;
	logic [31:0]      op_a;
	logic [31:0]      op_b;
	logic [31:0]      op_d;
	logic [31:0]      line_pc;

	// newest EX result wins over the register file
	function automatic logic [31:0] efp_opnd(input logic [REG_W-1:0] idx, input logic fwd,
		input logic [REG_W-1:0] fdst, input logic [31:0] fval, input logic [31:0] rval);
		efp_opnd = (fwd && fdst == idx) ? fval : rval;
	endfunction : efp_opnd

	function automatic logic [31:0] efp_alu(input efp_alu_type op, input logic [31:0] a, input logic [31:0] b);
		unique case (op)
			ALU_MOV: efp_alu = a;
			ALU_ADD: efp_alu = a + b;
			ALU_SUB: efp_alu = a - b;
			ALU_AND: efp_alu = a & b;
			ALU_OR:  efp_alu = a | b;
			ALU_XOR: efp_alu = a ^ b;
			ALU_SHL: efp_alu = a << b[4:0];
			ALU_SHR: efp_alu = a >> b[4:0];
			default: efp_alu = a - b;
		endcase
	endfunction : efp_alu

	efp_icache #(
		.WORDS (CACHE_WORDS)
	) u_icache (
		.clock      (clock),
		.rst_n      (rst_n),
		.rd_addr    (s_r.pc),
		.rd_data    (ic_data),
		.rd_hit     (ic_hit),
		.probe_addr (line_pc + LINE_STEP),
		.probe_hit  (probe_hit),
		.wr_en      (fill_wr),
		.wr_addr    (beat_addr),
		.wr_data    (fill_beat_data)
	);

	assign line_pc   = {s_r.pc[31:LINE_LSB], {LINE_LSB{1'b0}}};
	assign beat_addr = {s_r.fill_addr[31:LINE_LSB], s_r.fill_cnt, 2'h0};
	assign fill_wr   = (s_r.fst == F_BURST) && fill_beat_valid;
	// the word in flight feeds the decoder while it lands in the cache
	assign byp       = fill_wr && (beat_addr == s_r.pc);
	assign instr_ok  = ic_hit || byp;
	assign instr     = byp ? fill_beat_data : ic_data;

	assign fmt      = efp_fmt_of(instr[OPC_HI:OPC_LO]);
	assign f_dst    = instr[DST_HI:DST_LO];
	assign f_s1     = instr[SRC1_HI:SRC1_LO];
	assign f_s2     = instr[SRC2_HI:SRC2_LO];
	assign is_cond  = instr[OPC_LO+COND_BIT];
	assign is_store = instr[OPC_LO+STORE_BIT];
	assign is_mem   = (fmt == FMT_MEMA) || (fmt == FMT_MEMB);

	assign ex_fwd = s_r.ex_valid && (s_r.ex_op != ALU_CMP);
	assign ex_res = efp_alu(s_r.ex_op, s_r.ex_a, s_r.ex_b);
	assign op_a   = efp_opnd(f_s1, ex_fwd, s_r.ex_dst, ex_res, s_r.regs[f_s1]);
	assign op_b   = efp_opnd(f_s2, ex_fwd, s_r.ex_dst, ex_res, s_r.regs[f_s2]);
	assign op_d   = efp_opnd(f_dst, ex_fwd, s_r.ex_dst, ex_res, s_r.regs[f_dst]);

	// a scoreboarded operand, a pending compare for a conditional branch, a held memory slot for a memory access or a full load count for a load blocks issue
	always_comb
	begin
		unique case (fmt)
			FMT_CTRL: rdy = !(is_cond && s_r.cc_busy);
			FMT_COBR: rdy = !s_r.sb[f_s1] && !s_r.sb[f_s2];
			FMT_REG:  rdy = !s_r.sb[f_s1] && !s_r.sb[f_s2] && !s_r.sb[f_dst];
			FMT_MEMA, FMT_MEMB:
				rdy = !s_r.sb[f_s1] && !s_r.sb[f_dst] && (!s_r.mem_valid || mem_ready)
					&& (is_store || s_r.ld_cnt < LOAD_CAP);
			default:  rdy = 1'b1;
		endcase
	end
	assign issue = instr_ok && rdy;

	always_comb
	begin
		s_nxt        = s_r;
		s_nxt.issued = 1'b0;
		s_nxt.ex_valid = 1'b0;
		if (ld_rsp_valid)
		begin
			s_nxt.regs[ld_rsp_tag] = ld_rsp_data;
			s_nxt.sb[ld_rsp_tag]   = 1'b0;
		end
		if (s_r.ex_valid)
		begin
			if (s_r.ex_op == ALU_CMP)
			begin
				s_nxt.cc      = (s_r.ex_a == s_r.ex_b);
				s_nxt.cc_busy = 1'b0;
			end
			else
				s_nxt.regs[s_r.ex_dst] = ex_res;
		end
		if (s_r.mem_valid && mem_ready)
			s_nxt.mem_valid = 1'b0;
		unique case (s_r.fst)
			F_IDLE:
			begin
				if (!ic_hit)
				begin
					s_nxt.fst       = F_REQ;
					s_nxt.fill_addr = line_pc;
				end
				else if (!probe_hit)
				begin
					// keep one line ahead so sequential code rarely waits on the bus
					s_nxt.fst       = F_REQ;
					s_nxt.fill_addr = line_pc + LINE_STEP;
				end
			end
			F_REQ:
			begin
				if (fill_gnt)
				begin
					s_nxt.fst      = F_BURST;
					s_nxt.fill_cnt = 2'h0;
				end
			end
			F_BURST:
			begin
				if (fill_beat_valid)
				begin
					s_nxt.fill_cnt = s_r.fill_cnt + 2'h1;
					if (s_r.fill_cnt == LAST_BEAT)
						s_nxt.fst = F_IDLE;
				end
			end
			default: s_nxt.fst = F_IDLE;
		endcase
		if (issue)
		begin
			s_nxt.pc        = s_r.pc + WORD_STEP;
			s_nxt.issued    = 1'b1;
			s_nxt.issued_pc = s_r.pc;
			unique case (fmt)
				FMT_CTRL:
					if (!is_cond || s_r.cc)
						s_nxt.pc = s_r.pc + {{8{instr[DISP_HI]}}, instr[DISP_HI:DISP_LO], 2'h0};
				FMT_COBR:
				begin
					s_nxt.ex_valid = 1'b1;
					s_nxt.ex_op    = ALU_CMP;
					s_nxt.ex_a     = op_a;
					s_nxt.ex_b     = op_b;
					s_nxt.cc_busy  = 1'b1;
				end
				FMT_REG:
				begin
					s_nxt.ex_valid = 1'b1;
					s_nxt.ex_op    = (instr[OPC_LO+3:OPC_LO] == ALU_CMP) ? ALU_MOV
						: efp_alu_type'(instr[OPC_LO+3:OPC_LO]);
					s_nxt.ex_dst   = f_dst;
					s_nxt.ex_a     = op_a;
					s_nxt.ex_b     = op_b;
				end
				FMT_MEMA, FMT_MEMB:
				begin
					s_nxt.mem_valid = 1'b1;
					s_nxt.mem_write = is_store;
					s_nxt.mem_tag   = f_dst;
					s_nxt.mem_wdata = op_d;
					s_nxt.mem_addr  = (fmt == FMT_MEMA) ? op_a + {{20{instr[OFF_HI]}}, instr[OFF_HI:0]} : op_a;
					if (!is_store)
						s_nxt.sb[f_dst] = 1'b1;
				end
				default: s_nxt.pc = s_r.pc + WORD_STEP;
			endcase
		end
		s_nxt.ld_cnt = s_r.ld_cnt + {1'b0, issue && is_mem && !is_store} - {1'b0, ld_rsp_valid};
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			s_r    <= '0;
			s_r.pc <= RESET_PC;
		end
		else
			s_r <= s_nxt;
	end

	assign fill_req    = (s_r.fst == F_REQ);
	assign fill_addr   = s_r.fill_addr;
	assign mem_valid   = s_r.mem_valid;
	assign mem_write   = s_r.mem_write;
	assign mem_addr    = s_r.mem_addr;
	assign mem_wdata   = s_r.mem_wdata;
	assign mem_tag     = s_r.mem_tag;
	assign issue_pulse = s_r.issued;
	assign issue_pc    = s_r.issued_pc;

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	fill_align_a: assert property (fill_req |-> fill_addr[LINE_LSB-1:0] == '0)
		else $error("fill address not line aligned");
	// each outstanding load owns exactly one scoreboard bit, so the count must track the bits
	load_limit_a: assert property (s_r.ld_cnt <= LOAD_CAP && $countones(s_r.sb) == int'(s_r.ld_cnt))
		else $error("load count out of step with scoreboard");
	sb_set_a: assert property (issue && is_mem && !is_store |=> s_r.sb[$past(f_dst)] && mem_valid)
		else $error("load did not mark its destination");
	sb_clear_a: assert property (ld_rsp_valid |=> !s_r.sb[$past(ld_rsp_tag)])
		else $error("load return did not clear scoreboard");
	stall_hold_a: assert property (instr_ok && !issue |=> $stable(s_r.pc) && !issue_pulse)
		else $error("stalled instruction was not held");
	mem_only_a: assert property (issue && !is_mem && !s_r.mem_valid |=> !mem_valid)
		else $error("memory access from non memory instruction");
	bypass_a: assert property (issue && fmt == FMT_REG && ex_fwd && f_s1 == s_r.ex_dst
		|=> s_r.ex_a == $past(ex_res))
		else $error("ALU result not forwarded");
	burst_end_a: assert property (fill_wr && s_r.fill_cnt == LAST_BEAT |=> s_r.fst == F_IDLE)
		else $error("burst did not end after four beats");
	miss_pass_a: assert property (byp && rdy |=> issue_pulse && issue_pc == $past(s_r.pc))
		else $error("missed word not passed to decoder");
	alu_time_a: assert property (issue && fmt == FMT_REG |=> ex_fwd ##1 s_r.regs[$past(s_r.ex_dst)] == $past(ex_res))
		else $error("ALU result not written in time");

	three_loads_c: cover property (s_r.ld_cnt == LOAD_CAP && issue && !is_mem);
	miss_issue_c:  cover property (byp && issue);
	prefetch_c:    cover property (s_r.fst == F_IDLE && ic_hit && !probe_hit);
	cmp_pass_c:    cover property (s_r.cc_busy && issue && fmt == FMT_REG);
endmodule : efp_core

// >>> tb/efp_mem_model.sv
// Purpose: behavioural memory side of the fetch and issue pipeline
// Assumes: fills go out word 0 first; loads come back in order after lat cycles
// Notes:   slow mode delays grants, spaces beats and halves mem_ready
`timescale 1ns/1ps
module efp_mem_model (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        fill_req,
	input  wire logic [31:0] fill_addr,
	output logic             fill_gnt,
	output logic             fill_beat_valid,
	output logic      [31:0] fill_beat_data,
	input  wire logic        mem_valid,
	input  wire logic        mem_write,
	input  wire logic [31:0] mem_addr,
	input  wire logic [31:0] mem_wdata,
	input  wire logic [4:0]  mem_tag,
	output logic             mem_ready,
	output logic             ld_rsp_valid,
	output logic      [4:0]  ld_rsp_tag,
	output logic      [31:0] ld_rsp_data
);
	logic [31:0] prog [0:63];
	logic [31:0] base;
	logic [31:0] st_addr;
	logic [31:0] st_data;
	logic [4:0]  qtag [$];
	logic [31:0] qaddr [$];
	int          qdue [$];
	int          lat, cyc, nreq, maxout, ngrant, beat0_cyc;
	int          rsp_cyc [0:31];
	int          grant_cyc [0:3];
	bit          slow;

	always @(posedge clock) cyc <= cyc + 1;

	// idle data lines toggle so a stale word is never mistaken for a beat
	initial
	begin
		fill_gnt = 0;
		fill_beat_valid = 0;
		fill_beat_data = 32'h0;
		forever
		begin
			@(posedge clock);
			#1;
			fill_beat_data = ~fill_beat_data;
			if (rst_n === 1'b1 && fill_req === 1'b1)
			begin
				if (slow)
				begin
					repeat (2) @(posedge clock);
					#1;
				end
				// a reset that fell during the wait cancels this grant
				if (rst_n !== 1'b1)
					continue;
				fill_gnt = 1;
				base = fill_addr;
				ngrant++;
				if (base < 32'h40)
					grant_cyc[base[5:4]] = cyc;
				@(posedge clock);
				#1 fill_gnt = 0;
				for (int k = 0; k < 4 && rst_n; k++)
				begin
					if (slow)
					begin
						fill_beat_valid = 0;
						fill_beat_data = ~fill_beat_data;
						@(posedge clock);
						#1;
					end
					fill_beat_valid = 1;
					fill_beat_data = prog[6'(base[7:2] + k)];
					// only the first burst after reset marks the bypass timing
					if (k == 0 && ngrant == 1)
						beat0_cyc = cyc;
					@(posedge clock);
					#1;
				end
				fill_beat_valid = 0;
			end
		end
	end

	initial
	begin
		mem_ready = 0;
		ld_rsp_valid = 0;
		ld_rsp_tag = 5'h0;
		ld_rsp_data = 32'h0;
		forever
		begin
			@(posedge clock);
			if (rst_n === 1'b1 && mem_valid === 1'b1 && mem_ready === 1'b1)
			begin
				nreq++;
				if (mem_write)
				begin
					st_addr = mem_addr;
					st_data = mem_wdata;
				end
				else
				begin
					qtag.push_back(mem_tag);
					qaddr.push_back(mem_addr);
					qdue.push_back(cyc + lat);
					if (qtag.size() > maxout)
						maxout = qtag.size();
				end
			end
			#1;
			if (!rst_n)
			begin
				qtag.delete();
				qaddr.delete();
				qdue.delete();
			end
			mem_ready = slow ? ~mem_ready : 1'b1;
			ld_rsp_valid = 0;
			ld_rsp_tag = ~ld_rsp_tag;
			ld_rsp_data = ~ld_rsp_data;
			if (qtag.size() > 0 && qdue[0] <= cyc)
			begin
				ld_rsp_valid = 1;
				ld_rsp_tag = qtag.pop_front();
				ld_rsp_data = 32'hA000_0000 + qaddr.pop_front();
				void'(qdue.pop_front());
				rsp_cyc[ld_rsp_tag] = cyc;
			end
		end
	end
endmodule : efp_mem_model

// >>> tb/tb_top.sv
// Purpose: self-checking bench for the fetch and issue pipeline
// Assumes: unfilled program words are no-ops; registers start at zero
// Notes:   issue order is checked on every pulse by the monitor
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("MISMATCH %s exp=%0h got=%0h", nm, e, g); end end
module tb_top;
	import efp_pkg::*;
	logic             clock = 0;
	logic             rst_n = 0;
	logic             fill_req, fill_gnt, fill_beat_valid, mem_valid, mem_write, mem_ready;
	logic             ld_rsp_valid, issue_pulse;
	logic [31:0]      fill_addr, fill_beat_data, mem_addr, mem_wdata, ld_rsp_data, issue_pc;
	logic [REG_W-1:0] mem_tag, ld_rsp_tag;
	logic [31:0]      exp_pc;
	int               miscompares = 0;
	int               total_checks = 0;
	int               nissue;
	int               icyc [0:63];

	always #50 clock = ~clock;

	efp_core u_efp_core (.clock(clock), .rst_n(rst_n), .fill_req(fill_req), .fill_addr(fill_addr),
		.fill_gnt(fill_gnt), .fill_beat_valid(fill_beat_valid), .fill_beat_data(fill_beat_data),
		.mem_valid(mem_valid), .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_tag(mem_tag), .mem_ready(mem_ready), .ld_rsp_valid(ld_rsp_valid), .ld_rsp_tag(ld_rsp_tag),
		.ld_rsp_data(ld_rsp_data), .issue_pulse(issue_pulse), .issue_pc(issue_pc));
	efp_mem_model u_mem (.clock(clock), .rst_n(rst_n), .fill_req(fill_req), .fill_addr(fill_addr),
		.fill_gnt(fill_gnt), .fill_beat_valid(fill_beat_valid), .fill_beat_data(fill_beat_data),
		.mem_valid(mem_valid), .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_tag(mem_tag), .mem_ready(mem_ready), .ld_rsp_valid(ld_rsp_valid), .ld_rsp_tag(ld_rsp_tag),
		.ld_rsp_data(ld_rsp_data));

	function automatic logic [31:0] enc(input logic [7:0] op, input logic [4:0] d, s, input logic [11:0] lo);
		enc = {op, d, s, 2'h0, lo};
	endfunction : enc

	always @(posedge clock)
	begin
		if (rst_n === 1'b1 && issue_pulse === 1'b1)
		begin
			`CHK("issue_pc", exp_pc, issue_pc)
			exp_pc = exp_pc + WORD_STEP;
			nissue++;
			if (issue_pc < 32'h100 && icyc[issue_pc[7:2]] < 0)
				icyc[issue_pc[7:2]] = u_mem.cyc;
		end
		if (fill_req === 1'b1 && fill_gnt === 1'b1)
			`CHK("fill_addr", 4'h0, fill_addr[3:0])
	end

	task wrap_up;
		$display("checks=%0d miscompares=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up

	task do_reset(input bit slw, input int lt);
		@(posedge clock);
		#1 rst_n = 0;
		u_mem.slow = slw;
		u_mem.lat = lt;
		u_mem.nreq = 0;
		u_mem.maxout = 0;
		u_mem.ngrant = 0;
		for (int i = 0; i < 64; i++)
		begin
			u_mem.prog[i] = 32'h4000_0000;
			icyc[i] = -1;
		end
		for (int i = 0; i < 4; i++)
			u_mem.grant_cyc[i] = 99999;
		repeat (4) @(posedge clock);
		#1 rst_n = 1;
		exp_pc = RESET_PC;
		nissue = 0;
	endtask : do_reset

	// every wait is bounded; running out counts as a mismatch and ends the run
	task wait_for(input int n, input bit on_req);
		int k;
		k = 0;
		while ((on_req ? u_mem.nreq : nissue) < n && k < 500)
		begin
			@(posedge clock);
			#1 k++;
		end
		if ((on_req ? u_mem.nreq : nissue) < n)
		begin
			miscompares++;
			$display("MISMATCH timeout exp=%0d got=%0d", n, on_req ? u_mem.nreq : nissue);
			wrap_up();
		end
	endtask : wait_for

	task t_stream(input bit slw);
		do_reset(slw, 4);
		wait_for(20, 0);
		`CHK("bypass", u_mem.beat0_cyc + 1, icyc[0])
		`CHK("prefetch", 1'b1, u_mem.grant_cyc[1] < icyc[4])
		`CHK("bursts", 1'b1, u_mem.ngrant >= 5 && u_mem.ngrant <= 6)
		`CHK("no_data_access", 0, u_mem.nreq)
	endtask : t_stream

	task t_loads;
		do_reset(0, 20);
		u_mem.prog[0] = enc(8'h80, 5'd4, 5'd0, 12'h100);
		u_mem.prog[1] = enc(8'h80, 5'd5, 5'd0, 12'h104);
		u_mem.prog[2] = enc(8'h20, 5'd0, 5'd9, 12'h009);
		u_mem.prog[3] = enc(8'h50, 5'd10, 5'd0, 12'h000);
		u_mem.prog[4] = enc(8'h51, 5'd6, 5'd4, 12'h005);
		u_mem.prog[5] = enc(8'h81, 5'd6, 5'd0, 12'h200);
		wait_for(3, 1);
		`CHK("overlap", 1'b1, icyc[3] < u_mem.rsp_cyc[4])
		`CHK("cond_pass", icyc[2] + 1, icyc[3])
		`CHK("dep_wait", 1'b1, icyc[4] > u_mem.rsp_cyc[5])
		`CHK("prefetch_stall", 1'b1, u_mem.grant_cyc[2] < icyc[4])
		`CHK("st_addr", 32'h200, u_mem.st_addr)
		`CHK("st_data", 32'h4000_0204, u_mem.st_data)
		`CHK("nreq", 3, u_mem.nreq)
	endtask : t_loads

	task t_three(input bit slw);
		do_reset(slw, 30);
		for (int i = 0; i < 4; i++)
			u_mem.prog[i] = enc(8'h80, (i == 3) ? 5'd7 : 5'(i + 1), 5'd0, 12'(i * 16));
		u_mem.prog[4] = enc(8'h51, 5'd8, 5'd1, 12'h002);
		u_mem.prog[5] = enc(8'h81, 5'd8, 5'd0, 12'h300);
		wait_for(5, 1);
		`CHK("max_out", 3, u_mem.maxout)
		`CHK("fourth_held", 1'b1, icyc[3] > u_mem.rsp_cyc[1])
		`CHK("third_early", 1'b1, icyc[2] < u_mem.rsp_cyc[1])
		`CHK("sum", 32'h4000_0010, u_mem.st_data)
	endtask : t_three

	initial
	begin
		t_stream(0);
		t_stream(1);
		t_loads;
		t_three(1);
		wrap_up();
	end
endmodule : tb_top
